// >>> design/mlt_learn_table.sv
// Purpose: Source-address learning table with aging, per-VLAN and per-port enables and range walks.
// Assumes: Frame, request and configuration inputs come from logic on CORE_CLK.
// Notes:   Direct-mapped: a new address that hashes onto a used slot replaces its occupant.
//
// What this block does
// - Learn source address and receive port per frame.
// - Extended variant holds up to 32K entries.
// - Basic variant holds up to 16K entries.
// - Add new addresses; age out unused entries.
// - VLAN enable off clears that VLAN's entries.
// - Port enabled: learn only on enabled VLANs.
// - Port disabled: learn nothing on that port.
// - Retrieve by VLAN range; bounds 1 to 4093.
// - Retrieve or clear only in transport mode.
// - Basic variant returns only enabled-port entries.
// - Fixed readable address per client, trunk, CPU port.
`default_nettype none
`include "mlt_cfg.svh"

module mlt_learn_table #(
    parameter int          EXTENDED        = 1,   // One for the 32K variant, zero for the 16K variant.
    parameter int          NUM_CLIENT      = 8,
    parameter int          NUM_TRUNK       = 2,
    parameter int          AGE_STEP_CYCLES = `MLT_AGE_STEP_NS / `MLT_CLK_PERIOD_NS,
    parameter logic [47:0] BASE_MAC        = 48'h020000001000,  // Arbitrary value.
    parameter int          PW              = $clog2(NUM_CLIENT + NUM_TRUNK + 1)
) (
    input  wire logic                          CORE_CLK,
    input  wire logic                          RST_N,
    input  wire logic                          LAYER2_WAVELENGTH_TRANSPORT_MODE,
    input  wire logic [NUM_CLIENT+NUM_TRUNK-1:0] PORT_LEARN_EN,
    input  wire logic [`MLT_AGE_W-1:0]         AGE_LIMIT,
    input  wire logic                          FRM_VALID,
    output logic                               FRM_READY,
    input  wire logic [`MLT_MAC_W-1:0]         FRM_SRC_MAC,
    input  wire logic [`MLT_SVLAN_W-1:0]       FRM_SVLAN,
    input  wire logic [PW-1:0]                 FRM_PORT,
    input  wire logic                          VLAN_CFG_VALID,
    output logic                               VLAN_CFG_READY,
    input  wire logic [`MLT_SVLAN_W-1:0]       VLAN_CFG_ID,
    input  wire logic                          VLAN_CFG_EN,
    input  wire logic                          REQ_VALID,
    output logic                               REQ_READY,
    input  wire logic                          REQ_CLEAR,
    input  wire logic [`MLT_SVLAN_W-1:0]       REQ_LO,
    input  wire logic [`MLT_SVLAN_W-1:0]       REQ_HI,
    output logic                               REQ_REJECT,
    output logic                               REQ_DONE,
    output logic                               RET_VALID,
    input  wire logic                          RET_READY,
    output logic      [`MLT_MAC_W-1:0]         RET_MAC,
    output logic      [`MLT_SVLAN_W-1:0]       RET_SVLAN,
    output logic      [PW-1:0]                 RET_PORT,
    input  wire logic [PW-1:0]                 STATIC_SEL,
    output logic      [`MLT_MAC_W-1:0]         STATIC_MAC
);

    localparam int NPORT = NUM_CLIENT + NUM_TRUNK;                                    // CPU port is NPORT.
    localparam int DEPTH = (EXTENDED != 0) ? `MLT_ENTRIES_EXT : `MLT_ENTRIES_BASIC;
    localparam int IW    = $clog2(DEPTH);
    localparam int AGE_LSB = `MLT_PORT_LSB + PW;
    localparam int VAL_BIT = AGE_LSB + `MLT_AGE_W;
    localparam int EW      = VAL_BIT + 1;

    // Refuse shapes the hash, port field or step counter cannot serve.
    initial begin
        if (IW > 16 || NPORT < 1 || (1 << PW) <= NPORT || AGE_STEP_CYCLES < 1) begin
            $error("mlt_learn_table: unsupported parameter values");
        end
    end

    logic             rst_meta;   // First reset stage, read only by the second.
    logic             rst_n_i;    // Released reset used by all logic.
    mlt_pkg::mlt_state_t state;   // Sequencer state.
    mlt_pkg::mlt_state_t next_state;
    logic [4095:0]    vlan_en;    // Per-VLAN learning enables.
    logic             flush_pend; // A VLAN was switched off and its flush walk has not started yet.
    logic [`MLT_SVLAN_W-1:0] flush_id;
    logic [IW-1:0]    walk_ptr;   // Entry under the range walk.
    logic [`MLT_SVLAN_W-1:0] walk_lo;
    logic [`MLT_SVLAN_W-1:0] walk_hi;
    logic             walk_clear; // Walk removes rather than returns.
    logic             walk_sw;    // Walk was asked by software, so it ends with a done pulse.
    logic [IW-1:0]    sweep_ptr;  // Next entry to age.
    logic             sweep_pend; // An aging step is due.
    logic [31:0]      step_cnt;   // Cycles toward the next aging step.
    logic [EW-1:0]    rdata;      // Table read data.

    // Reset release through two flip-flops; assertion stays asynchronous.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n_i  <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_i  <= rst_meta;
        end
    end

    // Decoding of the current entry and of the incoming frame.
    wire [`MLT_SVLAN_W-1:0] ent_svlan = rdata[`MLT_SVLAN_LSB +: `MLT_SVLAN_W];
    wire [PW-1:0]           ent_port  = rdata[`MLT_PORT_LSB +: PW];
    wire [`MLT_AGE_W-1:0]   ent_age   = rdata[AGE_LSB +: `MLT_AGE_W];
    wire                    ent_valid = rdata[VAL_BIT];
    wire ent_port_en = (32'(ent_port) < NPORT) && PORT_LEARN_EN[ent_port];
    wire frm_port_en = (32'(FRM_PORT) < NPORT) && PORT_LEARN_EN[FRM_PORT];
    // A disabled port learns nothing; an enabled port learns only on enabled VLANs.
    wire learn_ok  = frm_port_en && vlan_en[FRM_SVLAN];
    // Fold the address and VLAN into an index; collisions simply replace.
    wire [15:0] hash16 = FRM_SRC_MAC[15:0] ^ FRM_SRC_MAC[31:16] ^ FRM_SRC_MAC[47:32] ^ {4'h0, FRM_SVLAN};
    wire [IW-1:0] frm_idx = hash16[IW-1:0];

    // Handshakes: sweeps and walks go first so that neither starves behind traffic.
    wire idle       = (state == mlt_pkg::ST_IDLE);
    assign REQ_READY      = idle && !flush_pend;
    assign FRM_READY      = idle && !flush_pend && !REQ_VALID && !sweep_pend;
    assign VLAN_CFG_READY = !flush_pend;
    wire frm_take   = FRM_VALID && FRM_READY;
    wire req_take   = REQ_VALID && REQ_READY;
    wire cfg_take   = VLAN_CFG_VALID && VLAN_CFG_READY;
    // Range must lie in 1..4093 and the card must be in transport mode.
    wire req_ok     = LAYER2_WAVELENGTH_TRANSPORT_MODE && (REQ_LO >= `MLT_SVLAN_MIN)
                      && (REQ_HI <= `MLT_SVLAN_MAX) && (REQ_LO <= REQ_HI);
    wire walk_start = idle && (flush_pend || (req_take && req_ok));
    wire walk_end   = (walk_ptr == IW'(DEPTH - 1));
    // An entry hits when valid and inside the inclusive range; the basic variant hides disabled ports from retrievals, not from clears.
    wire in_range   = ent_valid && (ent_svlan >= walk_lo) && (ent_svlan <= walk_hi);
    wire hit        = in_range && (walk_clear || EXTENDED != 0 || ent_port_en);
    wire age_out    = (ent_age >= AGE_LIMIT);
    // Both follow the next state, so an entry that was never written still advances the walk.
    wire walk_st    = (state == mlt_pkg::ST_WCHK) || (state == mlt_pkg::ST_WOUT);
    wire walk_leave = walk_st && (next_state == mlt_pkg::ST_IDLE);
    wire walk_step  = walk_st && (next_state == mlt_pkg::ST_WRD);
    assign RET_VALID = (state == mlt_pkg::ST_WOUT);

    // Memory port selection: learn in idle, age in the sweep states, walk otherwise.
    wire sweep_st  = (state == mlt_pkg::ST_SRD) || (state == mlt_pkg::ST_SWR);
    wire [IW-1:0] mem_addr = idle ? frm_idx : (sweep_st ? sweep_ptr : walk_ptr);
    wire learn_we  = idle && frm_take && learn_ok;
    wire age_we    = (state == mlt_pkg::ST_SWR) && ent_valid;
    wire clear_we  = (state == mlt_pkg::ST_WCHK) && hit && walk_clear;
    wire mem_we    = learn_we || age_we || clear_we;
    // A learn write stores age zero, which both adds a new entry and refreshes a known one.
    wire [EW-1:0] new_ent  = {1'b1, {`MLT_AGE_W{1'b0}}, FRM_PORT, FRM_SVLAN, FRM_SRC_MAC};
    wire [EW-1:0] aged_ent = {1'b1, ent_age + 1'b1, rdata[AGE_LSB-1:0]};
    wire [EW-1:0] mem_wdata = learn_we ? new_ent :
                              (age_we && !age_out) ? aged_ent : {EW{1'b0}};

    mlt_table_mem #(
        .WIDTH (EW),
        .DEPTH (DEPTH),
        .AW    (IW)
    ) u_mem (
        .clk   (CORE_CLK),
        .addr  (mem_addr),
        .we    (mem_we),
        .wdata (mem_wdata),
        .rdata (rdata)
    );

    // Next state of the sequencer.
    always_comb begin
        next_state = state;
        case (state)
            mlt_pkg::ST_IDLE: begin
                if (walk_start) begin
                    next_state = mlt_pkg::ST_WRD;
                end else if (sweep_pend) begin
                    next_state = mlt_pkg::ST_SRD;
                end
            end
            mlt_pkg::ST_SRD:  next_state = mlt_pkg::ST_SWR;
            mlt_pkg::ST_SWR:  next_state = mlt_pkg::ST_IDLE;
            mlt_pkg::ST_WRD:  next_state = mlt_pkg::ST_WCHK;
            mlt_pkg::ST_WCHK: begin
                if (hit && !walk_clear) begin
                    next_state = mlt_pkg::ST_WOUT;
                end else if (walk_end) begin
                    next_state = mlt_pkg::ST_IDLE;
                end else begin
                    next_state = mlt_pkg::ST_WRD;
                end
            end
            mlt_pkg::ST_WOUT: begin
                if (RET_READY) begin
                    next_state = walk_end ? mlt_pkg::ST_IDLE : mlt_pkg::ST_WRD;
                end
            end
            default:          next_state = mlt_pkg::ST_IDLE;
        endcase
    end

    // Sequencer state and walk bookkeeping.
    always_ff @(posedge CORE_CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= mlt_pkg::ST_IDLE;
            walk_ptr   <= '0;
            walk_lo    <= '0;
            walk_hi    <= '0;
            walk_clear <= 1'b0;
            walk_sw    <= 1'b0;
        end else begin
            state <= next_state;
            if (walk_start) begin
                // A pending flush is a clear walk over one VLAN and beats a software request.
                walk_ptr   <= '0;
                walk_lo    <= flush_pend ? flush_id : REQ_LO;
                walk_hi    <= flush_pend ? flush_id : REQ_HI;
                walk_clear <= flush_pend ? 1'b1 : REQ_CLEAR;
                walk_sw    <= !flush_pend;
            end else if (walk_step) begin
                walk_ptr <= walk_ptr + 1'b1;
            end
        end
    end

    // Per-VLAN enables; switching one off schedules a flush of its entries.
    always_ff @(posedge CORE_CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vlan_en    <= {4096{`MLT_VLAN_EN_RESET}};
            flush_pend <= 1'b0;
            flush_id   <= '0;
        end else begin
            if (walk_start && flush_pend) begin
                flush_pend <= 1'b0;
            end
            if (cfg_take) begin
                vlan_en[VLAN_CFG_ID] <= VLAN_CFG_EN;
                if (vlan_en[VLAN_CFG_ID] && !VLAN_CFG_EN) begin
                    flush_pend <= 1'b1;
                    flush_id   <= VLAN_CFG_ID;
                end
            end
        end
    end

    // Aging clock: one entry is visited every step, so the idle interval is
    // roughly AGE_LIMIT times the table depth times the step.
    always_ff @(posedge CORE_CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_cnt   <= '0;
            sweep_pend <= 1'b0;
            sweep_ptr  <= '0;
        end else begin
            if (idle && !walk_start && sweep_pend) begin
                sweep_pend <= 1'b0;
            end
            if (step_cnt == 32'(AGE_STEP_CYCLES - 1)) begin
                step_cnt   <= '0;
                sweep_pend <= 1'b1;
            end else begin
                step_cnt <= step_cnt + 32'h1;
            end
            if (state == mlt_pkg::ST_SWR) begin
                sweep_ptr <= sweep_ptr + 1'b1;
            end
        end
    end

    // Answer pulses and the captured entry offered to the consumer.
    always_ff @(posedge CORE_CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            REQ_REJECT <= 1'b0;
            REQ_DONE   <= 1'b0;
            RET_MAC    <= '0;
            RET_SVLAN  <= '0;
            RET_PORT   <= '0;
            STATIC_MAC <= '0;
        end else begin
            REQ_REJECT <= req_take && !req_ok;
            REQ_DONE   <= walk_leave && walk_sw;
            if (state == mlt_pkg::ST_WCHK && hit) begin
                RET_MAC   <= rdata[`MLT_MAC_LSB +: `MLT_MAC_W];
                RET_SVLAN <= ent_svlan;
                RET_PORT  <= ent_port;
            end
            // Fixed per-port address; index NPORT is the CPU port.
            STATIC_MAC <= (32'(STATIC_SEL) <= NPORT) ? BASE_MAC + 48'(STATIC_SEL) : '0;
        end
    end

endmodule

`default_nettype wire

// >>> common/mlt_cfg.svh
// Purpose: Constants for the address learning table: sizes, field positions, limits and timing.
// Assumes: A 40 MHz core clock.
// Notes:   Included by bare name; definitions only.
`ifndef MLT_CFG_SVH
`define MLT_CFG_SVH

// Table sizes of the two card variants.
`define MLT_ENTRIES_EXT    32768
`define MLT_ENTRIES_BASIC  16384

// Field widths of one entry.
`define MLT_MAC_W          48
`define MLT_SVLAN_W        12
`define MLT_AGE_W          4

// Field positions inside one entry; port, age and valid follow the service VLAN.
`define MLT_MAC_LSB        0
`define MLT_SVLAN_LSB      48
`define MLT_PORT_LSB       60

// Legal bounds of a retrieve or clear range.
`define MLT_SVLAN_MIN      12'h001
`define MLT_SVLAN_MAX      12'hFFD

// Reset value of each per-VLAN learning enable.
`define MLT_VLAN_EN_RESET  1'b0

// Aging step: one table entry is visited per step.
`define MLT_CLK_PERIOD_NS  25
`define MLT_AGE_STEP_NS    25000

`endif

// >>> common/mlt_pkg.sv
// Purpose: Types shared by the address learning table.
// Assumes: Nothing beyond the configuration header.
// Notes:   States are Gray coded along the usual path.
`default_nettype none

package mlt_pkg;

    // Engine states of the table sequencer.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,  // Free: frames are learned here.
        ST_SRD  = 3'h1,  // Aging read of one entry.
        ST_SWR  = 3'h3,  // Aging write-back of that entry.
        ST_WRD  = 3'h2,  // Range walk read.
        ST_WCHK = 3'h6,  // Range walk compare, clear or capture.
        ST_WOUT = 3'h7   // Retrieved entry offered to the consumer.
    } mlt_state_t;

endpackage

`default_nettype wire

// >>> design/mlt_table_mem.sv
// Purpose: Single-port table memory with registered read data.
// Assumes: One access per cycle; a write does not update read data.
// Notes:   Width and depth are parameters; contents are not reset.
`default_nettype none

module mlt_table_mem #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 32768,
    parameter int AW    = 15
) (
    input  wire logic             clk,    // Core clock.
    input  wire logic [AW-1:0]    addr,   // Entry index.
    input  wire logic             we,     // Write strobe.
    input  wire logic [WIDTH-1:0] wdata,  // Write data.
    output logic      [WIDTH-1:0] rdata   // Read data of the previous cycle's address.
);

    // Refuse an address width that cannot reach every entry.
    initial begin
        if ((1 << AW) < DEPTH || DEPTH < 2) begin
            $error("mlt_table_mem: address width does not fit the depth");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];  // Storage; valid bits are cleared by the owner, not by reset.

    // Read before write, read out through a register so the array maps onto block RAM.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule

`default_nettype wire

// >>> verif/mlt_learn_table_monitor.sv
// Purpose: Port-level assertions for the address learning table.
// Assumes: Parameters match the bound instance; one clock.
// Notes:   Checks wait until the internal reset copy has let go.
`default_nettype none
`include "mlt_cfg.svh"

module mlt_learn_table_monitor #(
    parameter int          EXTENDED   = 1,
    parameter int          NUM_CLIENT = 8,
    parameter int          NUM_TRUNK  = 2,
    parameter logic [47:0] BASE_MAC   = 48'h020000001000,  // Arbitrary value.
    parameter int          PW         = 4,
    parameter int          NP         = NUM_CLIENT + NUM_TRUNK
) (
    input wire logic                    CORE_CLK,
    input wire logic                    RST_N,
    input wire logic                    LAYER2_WAVELENGTH_TRANSPORT_MODE,
    input wire logic [NP-1:0]           PORT_LEARN_EN,
    input wire logic                    VLAN_CFG_VALID,
    input wire logic                    VLAN_CFG_READY,
    input wire logic [`MLT_SVLAN_W-1:0] VLAN_CFG_ID,
    input wire logic                    VLAN_CFG_EN,
    input wire logic                    REQ_VALID,
    input wire logic                    REQ_READY,
    input wire logic [`MLT_SVLAN_W-1:0] REQ_LO,
    input wire logic [`MLT_SVLAN_W-1:0] REQ_HI,
    input wire logic                    REQ_REJECT,
    input wire logic                    REQ_DONE,
    input wire logic                    RET_VALID,
    input wire logic                    RET_READY,
    input wire logic [`MLT_MAC_W-1:0]   RET_MAC,
    input wire logic [`MLT_SVLAN_W-1:0] RET_SVLAN,
    input wire logic [PW-1:0]           RET_PORT,
    input wire logic [PW-1:0]           STATIC_SEL,
    input wire logic [`MLT_MAC_W-1:0]   STATIC_MAC
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0]    live_cnt;  // Edges since reset release, saturating.
    logic          live;      // High once the design's own reset copy is gone.
    logic [11:0]   lo_q;      // Lower bound of the last request taken.
    logic [11:0]   hi_q;      // Upper bound of the last request taken.
    logic [4095:0] ven;       // Mirror of the per-VLAN learning enables.
    logic          take;      // A request is taken at this edge.
    logic          bad;       // The request taken should be refused.
    logic          cfg_off;   // An enabled VLAN is being switched off.

    assign live    = live_cnt == 2'h3;
    assign take    = REQ_VALID && REQ_READY;
    assign bad     = !LAYER2_WAVELENGTH_TRANSPORT_MODE || REQ_LO < `MLT_SVLAN_MIN
                     || REQ_HI > `MLT_SVLAN_MAX || REQ_LO > REQ_HI;
    assign cfg_off = VLAN_CFG_VALID && VLAN_CFG_READY && !VLAN_CFG_EN && ven[VLAN_CFG_ID];

    // The mirrors follow the accepted configuration and requests, so they drop with reset.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            live_cnt <= 2'h0;
            lo_q     <= 12'h000;
            hi_q     <= 12'h000;
            ven      <= '0;
        end else begin
            live_cnt <= live ? live_cnt : live_cnt + 2'h1;
            lo_q     <= take ? REQ_LO : lo_q;
            hi_q     <= take ? REQ_HI : hi_q;
            if (VLAN_CFG_VALID && VLAN_CFG_READY) begin
                ven[VLAN_CFG_ID] <= VLAN_CFG_EN;
            end
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!live);

    a_reject_mode: assert property (take && !LAYER2_WAVELENGTH_TRANSPORT_MODE |=> REQ_REJECT)
        else $error("request outside transport mode was not refused");
    a_reject_bounds: assert property (take && bad |=> REQ_REJECT)
        else $error("request with illegal bounds was not refused");
    a_accept_good: assert property (take && !bad |=> (!REQ_REJECT && !REQ_DONE) [*2])
        else $error("legal request refused or ended at once");
    a_ret_range: assert property (RET_VALID |-> RET_SVLAN >= lo_q && RET_SVLAN <= hi_q)
        else $error("retrieved entry outside requested range");
    a_ret_hold: assert property (RET_VALID && !RET_READY |=> RET_VALID && $stable(RET_MAC)
        && $stable(RET_SVLAN) && $stable(RET_PORT)) else $error("retrieved entry changed while stalled");
    a_ret_port_on: assert property (RET_VALID && EXTENDED == 0 |-> PORT_LEARN_EN[RET_PORT])
        else $error("entry of a disabled port retrieved");
    a_static_addr: assert property (1'b1 |=> STATIC_MAC == ($past(STATIC_SEL) <= NP
        ? BASE_MAC + 48'($past(STATIC_SEL)) : 48'h0)) else $error("fixed port address wrong");
    a_flush_block: assert property (cfg_off |=> !VLAN_CFG_READY && !REQ_READY)
        else $error("switch-off of a VLAN did not start a flush");
    a_done_quiet: assert property (REQ_DONE |-> !RET_VALID && !REQ_REJECT)
        else $error("walk ended while an entry was offered");

    c_refused: cover property (REQ_REJECT);
    c_stall: cover property (RET_VALID && !RET_READY ##1 RET_VALID && RET_READY);
    c_flush: cover property (cfg_off);
    c_done: cover property (REQ_DONE);
endmodule

bind mlt_learn_table mlt_learn_table_monitor #(.EXTENDED(EXTENDED), .NUM_CLIENT(NUM_CLIENT),
    .NUM_TRUNK(NUM_TRUNK), .BASE_MAC(BASE_MAC), .PW(PW)) mon_i (.*);
`default_nettype wire

// >>> verif/mlt_port_peer.sv
// Purpose: Model of the switch ports feeding frames to the table.
// Assumes: A frame is taken at a rising edge with ready high.
// Notes:   Released lines carry the inverse of the last frame.
`default_nettype none

module mlt_port_peer #(
    parameter int PW = 4
) (
    input  wire logic          clk,    // Core clock.
    input  wire logic          ready,  // Table accepts a frame.
    output logic               valid,  // Frame offered.
    output logic [47:0]        mac,    // Source address.
    output logic [11:0]        svlan,  // Service VLAN.
    output logic [PW-1:0]      port    // Receiving port.
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle until the first frame.
    initial {valid, mac, svlan, port} = '0;

    // Offers a frame from a falling edge and holds it until taken.
    task automatic send(input logic [47:0] m, input logic [11:0] v, input logic [PW-1:0] p);
        int n = 0;
        @(negedge clk);
        {valid, mac, svlan, port} = {1'b1, m, v, p};
        do @(posedge clk); while (ready !== 1'b1 && ++n < 200);
        @(negedge clk);
        {valid, mac, svlan, port} = {1'b0, ~m, ~v, ~p};
    endtask
endmodule
`default_nettype wire

// >>> verif/mlt_learn_table_test.sv
// Purpose: Self-checking bench for the learning table, basic variant.
// Assumes: Each walk visits all 16K entries, some 33K cycles.
// Notes:   Aging is slowed so learned entries survive.
`default_nettype none
`include "mlt_cfg.svh"

module mlt_learn_table_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 4;

    logic          core_clk, rst_n, mode, vcfg_valid, vcfg_ready, vcfg_en, req_valid, req_ready;
    logic          req_clear, req_reject, req_done, frm_valid, frm_ready, ret_valid, ret_ready;
    logic [9:0]    port_en;
    logic [11:0]   vcfg_id, req_lo, req_hi, ret_svlan, frm_svlan;
    logic [47:0]   ret_mac, frm_mac, static_mac;
    logic [PW-1:0] ret_port, frm_port, static_sel;
    logic [47:0]   mac_r[6];   // Random source addresses.
    logic [77:0]   exp_q[$];   // Expected entries: index, address, VLAN, port.
    logic [77:0]   got;        // Lowest-index expected entry.
    logic          exp_rej[$]; // Expected outcome of each request, one for a refusal.
    int            err_total, checks;
    int            seed = 32'h33e7;

    mlt_learn_table #(.EXTENDED(0), .AGE_STEP_CYCLES(4096)) DUT (
        .CORE_CLK(core_clk), .RST_N(rst_n), .LAYER2_WAVELENGTH_TRANSPORT_MODE(mode),
        .PORT_LEARN_EN(port_en), .AGE_LIMIT(4'hF), .FRM_VALID(frm_valid), .FRM_READY(frm_ready),
        .FRM_SRC_MAC(frm_mac), .FRM_SVLAN(frm_svlan), .FRM_PORT(frm_port), .VLAN_CFG_VALID(vcfg_valid),
        .VLAN_CFG_READY(vcfg_ready), .VLAN_CFG_ID(vcfg_id), .VLAN_CFG_EN(vcfg_en), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_CLEAR(req_clear), .REQ_LO(req_lo), .REQ_HI(req_hi),
        .REQ_REJECT(req_reject), .REQ_DONE(req_done), .RET_VALID(ret_valid), .RET_READY(ret_ready),
        .RET_MAC(ret_mac), .RET_SVLAN(ret_svlan), .RET_PORT(ret_port), .STATIC_SEL(static_sel),
        .STATIC_MAC(static_mac));

    mlt_port_peer #(.PW(PW)) peer (.clk(core_clk), .ready(frm_ready), .valid(frm_valid),
        .mac(frm_mac), .svlan(frm_svlan), .port(frm_port));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
        checks++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Files an entry in index order, as a walk returns them.
    task automatic expect_entry(input logic [47:0] m, input logic [11:0] v, input logic [PW-1:0] p);
        logic [13:0] idx;
        int          i;
        idx = m[13:0] ^ m[29:16] ^ m[45:32] ^ {2'h0, v};
        i = 0;
        while (i < exp_q.size() && exp_q[i][77:64] < idx) i++;
        exp_q.insert(i, {idx, m, v, p});
    endtask

    task automatic vlan_cfg(input logic [11:0] id, input logic en);
        int n = 0;
        @(negedge core_clk);
        {vcfg_valid, vcfg_id, vcfg_en} = {1'b1, id, en};
        do @(posedge core_clk); while (vcfg_ready !== 1'b1 && ++n < 40000);
        @(negedge core_clk);
        vcfg_valid = 1'b0;
    endtask

    // Holds a request until taken, then until its outcome is compared.
    task automatic request(input logic clr, input logic [11:0] lo, input logic [11:0] hi, input logic rej);
        int n = 0;
        exp_rej.push_back(rej);
        @(negedge core_clk);
        {req_valid, req_clear, req_lo, req_hi} = {1'b1, clr, lo, hi};
        do @(posedge core_clk); while (req_ready !== 1'b1 && ++n < 40000);
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (exp_rej.size() != 0 && n++ < 40000) @(posedge core_clk);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Random consumer stalls and fixed-address selections.
    always @(negedge core_clk) begin
        ret_ready <= $random(seed) % 2 != 0;
        static_sel <= PW'($random(seed));
    end

    // Compares each entry with the lowest-index note and each outcome with the oldest.
    always @(posedge core_clk) begin
        if (ret_valid === 1'b1 && ret_ready === 1'b1) begin
            got = exp_q.size() != 0 ? exp_q.pop_front() : ~{14'h0, ret_mac, ret_svlan, ret_port};
            check("retrieved entry", {ret_mac, ret_svlan, ret_port}, got[63:0]);
        end
        if (req_done === 1'b1 || req_reject === 1'b1) begin
            check("request refused", {63'h0, req_reject}, {63'h0, exp_rej.pop_front()});
            if (req_done === 1'b1) check("entries missing", 64'(exp_q.size()), 64'h0);
        end
    end

    // Three 33K-cycle walks bound the run; a small margin above.
    initial begin
        repeat (103000) @(posedge core_clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        {rst_n, vcfg_valid, vcfg_en, req_valid, req_clear, ret_ready} = 6'h00;
        {vcfg_id, req_lo, req_hi, static_sel} = '0;
        mode = 1'b1;
        port_en = 10'h3FB; // Port 2 never learns.
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        foreach (mac_r[i]) mac_r[i] = {16'($random(seed)), 32'($random(seed))};
        vlan_cfg(12'h004, 1'b1);
        vlan_cfg(12'h005, 1'b1);
        vlan_cfg(12'h006, 1'b1);
        vlan_cfg(12'h009, 1'b1);
        vlan_cfg(12'hFFD, 1'b1);
        request(1'b1, `MLT_SVLAN_MIN, `MLT_SVLAN_MAX, 1'b0);
        @(negedge core_clk);
        mode = 1'b0;
        request(1'b0, 12'h001, 12'h005, 1'b1);
        @(negedge core_clk);
        mode = 1'b1;
        request(1'b0, 12'h000, 12'h005, 1'b1);
        request(1'b0, 12'h001, 12'hFFE, 1'b1);
        request(1'b1, 12'h009, 12'h008, 1'b1);
        peer.send(mac_r[0], 12'h005, 4'h1);
        peer.send(mac_r[1], 12'h005, 4'h1);
        peer.send(mac_r[0], 12'h005, 4'h1);
        peer.send(mac_r[2], 12'h006, 4'h3);
        peer.send(mac_r[3], 12'h007, 4'h1);
        peer.send(mac_r[4], 12'h009, 4'h2);
        peer.send(mac_r[5], 12'h009, 4'h4);
        peer.send(~mac_r[1], 12'hFFD, 4'h0);
        peer.send(~mac_r[0], 12'h004, 4'h0);
        expect_entry(mac_r[0], 12'h005, 4'h1);
        expect_entry(mac_r[1], 12'h005, 4'h1);
        expect_entry(~mac_r[1], 12'hFFD, 4'h0);
        vlan_cfg(12'h006, 1'b0);
        @(negedge core_clk);
        port_en = 10'h3EB; // Port 4 stops learning before retrieval.
        request(1'b0, 12'h005, `MLT_SVLAN_MAX, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
